// ---- common/cpab_regs.svh ----
`ifndef CPAB_REGS_SVH
`define CPAB_REGS_SVH

// ---------------------------------------------------------------
// register map, byte addresses on the apb slave
// ---------------------------------------------------------------
`define CPAB_ADDR_W 8
`define CPAB_OFS_CTRL 8'h00
`define CPAB_OFS_WRITE_DATA 8'h04
`define CPAB_OFS_SHIFT 8'h08
`define CPAB_OFS_WORK_ONE 8'h0c
`define CPAB_OFS_WORK_TWO 8'h10

// ---------------------------------------------------------------
// fields and reset values
// ---------------------------------------------------------------
`define CPAB_CTRL_TESTER_EN 0
`define CPAB_CTRL_RESET 32'h0000_0001
`define CPAB_WORD_RESET 32'h0000_0000
`define CPAB_ZERO16 16'h0000

// ---------------------------------------------------------------
// datapath geometry
// ---------------------------------------------------------------
`define CPAB_BYTE_W 8
`define CPAB_HALF_W 16
`define CPAB_SHIFT_ONE 1
`define CPAB_SHIFT_NIBBLE 4

`endif

// ---- common/cpab_pkg.sv ----
package cpab_pkg;

  // byte selection modes from the two microinstruction bits
  typedef enum logic [1:0] {
    CPAB_BSEL_ALL,
    CPAB_BSEL_SINGLE,
    CPAB_BSEL_PARTIAL,
    CPAB_BSEL_NONE
  } cpab_bsel_t;

  // byte rotator function select
  typedef enum logic [1:0] {
    CPAB_ROT_PASS,
    CPAB_ROT_SWAP16,
    CPAB_ROT_LEFT8,
    CPAB_ROT_RIGHT8
  } cpab_rot_t;

  // shift register function
  typedef enum logic [1:0] {
    CPAB_SHF_PASS,
    CPAB_SHF_RIGHT1,
    CPAB_SHF_RIGHT4,
    CPAB_SHF_LEFT4
  } cpab_shf_t;

  // a bus operand that feeds the shift register
  typedef enum logic [1:0] {
    CPAB_SRC_NONE,
    CPAB_SRC_WRITE_REG,
    CPAB_SRC_WORK_ONE,
    CPAB_SRC_WORK_TWO
  } cpab_src_t;

endpackage

// ---- logic/cpab_datapath.sv ----
`timescale 1ns/10ps
`include "cpab_regs.svh"

module cpab_datapath #(
  parameter int DATA_W = 32
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic [DATA_W-1:0] result_bus_data_i,
  input wire logic [DATA_W-1:0] memory_read_data_i,
  input wire logic mem_read_i,
  input wire logic load_rd_two_i,
  input wire logic load_rd_three_i,
  input wire logic load_write_reg_i,
  input wire logic load_mult_a_i,
  input wire logic load_mult_b_i,
  input wire logic rd_sel_three_i,
  input wire cpab_pkg::cpab_bsel_t byte_sel_i,
  input wire logic [2:0] operand_address_reg_one_lo_i,
  input wire cpab_pkg::cpab_rot_t rotate_func_i,
  input wire cpab_pkg::cpab_shf_t shift_func_i,
  input wire cpab_pkg::cpab_src_t shift_src_i,
  input wire logic work_sel_mult_i,
  input wire logic store_clock_op_i,
  input wire logic clock_to_high_i,
  input wire logic [15:0] prog_clock_i,
  input wire logic load_work_one_i,
  input wire logic load_work_two_i,
  input wire logic mult_xlate_op_i,
  input wire logic mult_ripple_op_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [`CPAB_ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [DATA_W-1:0] a_mux_data_o,
  output logic [DATA_W-1:0] memory_write_data_o,
  output logic [DATA_W-1:0] tester_data_o,
  output logic pready_o,
  output logic [31:0] prdata_o,
  output logic pslverr_o
);
  import cpab_pkg::*;

  // -------------------------------------------------------------
  // helper functions
  // -------------------------------------------------------------
  function automatic logic [31:0] byte_mask(input cpab_bsel_t sel,
                                            input logic [2:0] adr);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int b = 0; b < 4; b++) begin
      unique case (sel)
        CPAB_BSEL_ALL: m[b*8 +: 8] = 8'hff;
        CPAB_BSEL_SINGLE: m[b*8 +: 8] = (2'(b) == adr[1:0]) ? 8'hff : 8'h00;
        // partial: tail from the offset, or head up to it when bit two set
        CPAB_BSEL_PARTIAL: m[b*8 +: 8] =
          (adr[2] ? (2'(b) <= adr[1:0]) : (2'(b) >= adr[1:0]))
          ? 8'hff : 8'h00;
        CPAB_BSEL_NONE: m[b*8 +: 8] = 8'h00;
      endcase
    end
    return m;
  endfunction
  // product from four 8x8 sections, summed like the board's adder stage
  function automatic logic [31:0] mult16(input logic [15:0] a,
                                         input logic [15:0] b);
    logic [31:0] ll, lh, hl, hh;
    // widen first: a bare 8x8 product inside a concatenation keeps 8 bits
    ll = {16'h0000, 16'(a[7:0]) * 16'(b[7:0])};
    lh = {16'h0000, 16'(a[7:0]) * 16'(b[15:8])};
    hl = {16'h0000, 16'(a[15:8]) * 16'(b[7:0])};
    hh = {16'h0000, 16'(a[15:8]) * 16'(b[15:8])};
    return ll + (lh << `CPAB_BYTE_W) + (hl << `CPAB_BYTE_W)
           + (hh << `CPAB_HALF_W);
  endfunction

  // -------------------------------------------------------------
  // declarations
  // -------------------------------------------------------------
  logic [DATA_W-1:0] in_mux, read_data_reg_two, read_data_reg_three;
  logic [DATA_W-1:0] write_data_reg, mult_buf_a_reg, mult_buf_b_reg;
  logic [2*DATA_W-1:0] memory_write_buffer_reg;
  logic [DATA_W-1:0] tester_reg, work_reg_one, work_reg_two, shift_reg;
  logic [DATA_W-1:0] shift_next, shift_in, selected_bytes, rotate_out;
  logic [DATA_W-1:0] a_mux_reg, product, work_next;
  logic [15:0] mult_op_a, mult_op_b;
  logic mult_buf_en, work_mux_en, apb_write;
  logic [31:0] ctrl_reg, prdata_reg;
  logic pready_reg, pslverr_reg;

  // -------------------------------------------------------------
  // input mux and memory data registers
  // -------------------------------------------------------------
  assign in_mux = mem_read_i ? memory_read_data_i
                             : result_bus_data_i;
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      read_data_reg_two <= `CPAB_WORD_RESET;
      read_data_reg_three <= `CPAB_WORD_RESET;
      write_data_reg <= `CPAB_WORD_RESET;
    end else begin
      if (load_rd_two_i) begin
        read_data_reg_two <= in_mux;
      end
      if (load_rd_three_i) begin
        read_data_reg_three <= in_mux;
      end
      if (load_write_reg_i) begin
        write_data_reg <= in_mux;
      end
    end
  end

  // -------------------------------------------------------------
  // byte selection and rotator
  // -------------------------------------------------------------
  // register choice comes from the memory controller gating
  assign selected_bytes = (rd_sel_three_i ? read_data_reg_three
                                          : read_data_reg_two)
                          & byte_mask(byte_sel_i,
                                      operand_address_reg_one_lo_i);
  always_comb begin
    unique case (rotate_func_i)
      CPAB_ROT_PASS: rotate_out = selected_bytes;
      CPAB_ROT_SWAP16: rotate_out = {selected_bytes[15:0],
                                     selected_bytes[31:16]};
      CPAB_ROT_LEFT8: rotate_out = {selected_bytes[23:0],
                                    selected_bytes[31:24]};
      CPAB_ROT_RIGHT8: rotate_out = {selected_bytes[7:0],
                                     selected_bytes[31:8]};
    endcase
  end
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      a_mux_reg <= `CPAB_WORD_RESET;
    end else begin
      a_mux_reg <= rotate_out | shift_reg;
    end
  end

  // -------------------------------------------------------------
  // write buffer toward memory and tester copy
  // -------------------------------------------------------------
  // tester copy can be frozen by software to inspect a captured word
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      memory_write_buffer_reg <= {`CPAB_WORD_RESET, `CPAB_WORD_RESET};
      tester_reg <= `CPAB_WORD_RESET;
    end else begin
      memory_write_buffer_reg <= {2{write_data_reg}};
      if (ctrl_reg[`CPAB_CTRL_TESTER_EN]) begin
        tester_reg <= write_data_reg;
      end
    end
  end

  // -------------------------------------------------------------
  // multiplier buffers and multiplier
  // -------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      mult_buf_a_reg <= `CPAB_WORD_RESET;
      mult_buf_b_reg <= `CPAB_WORD_RESET;
    end else begin
      if (load_mult_a_i) begin
        mult_buf_a_reg <= in_mux;
      end
      if (load_mult_b_i) begin
        mult_buf_b_reg <= write_data_reg;
      end
    end
  end
  assign mult_buf_en = mult_xlate_op_i | mult_ripple_op_i;
  assign mult_op_a = mult_buf_en ? mult_buf_a_reg[15:0] : `CPAB_ZERO16;
  assign mult_op_b = mult_buf_en ? mult_buf_b_reg[15:0] : `CPAB_ZERO16;
  assign product = mult16(mult_op_a, mult_op_b);

  // -------------------------------------------------------------
  // work muxes and work registers
  // -------------------------------------------------------------
  assign work_mux_en = !store_clock_op_i;
  always_comb begin
    work_next = `CPAB_WORD_RESET;
    if (work_mux_en) begin
      // both halves share one select, as the two muxes do
      work_next[31:16] = work_sel_mult_i ? product[31:16]
                                         : result_bus_data_i[31:16];
      work_next[15:0] = work_sel_mult_i ? product[15:0]
                                        : result_bus_data_i[15:0];
    end else if (clock_to_high_i) begin
      work_next[31:16] = prog_clock_i;
    end else begin
      work_next[15:0] = prog_clock_i;
    end
  end
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      work_reg_one <= `CPAB_WORD_RESET;
      work_reg_two <= `CPAB_WORD_RESET;
    end else begin
      if (load_work_one_i) begin
        work_reg_one <= work_next;
      end
      if (load_work_two_i) begin
        work_reg_two <= work_next;
      end
    end
  end

  // -------------------------------------------------------------
  // shift register
  // -------------------------------------------------------------
  // with no a bus operand the shifter works on its own content
  always_comb begin
    unique case (shift_src_i)
      CPAB_SRC_NONE: shift_in = shift_reg;
      CPAB_SRC_WRITE_REG: shift_in = write_data_reg;
      CPAB_SRC_WORK_ONE: shift_in = work_reg_one;
      CPAB_SRC_WORK_TWO: shift_in = work_reg_two;
    endcase
  end
  always_comb begin
    unique case (shift_func_i)
      CPAB_SHF_PASS: shift_next = shift_in;
      CPAB_SHF_RIGHT1: shift_next = shift_in >> `CPAB_SHIFT_ONE;
      CPAB_SHF_RIGHT4: shift_next = shift_in >> `CPAB_SHIFT_NIBBLE;
      CPAB_SHF_LEFT4: shift_next = shift_in << `CPAB_SHIFT_NIBBLE;
    endcase
  end
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      shift_reg <= `CPAB_WORD_RESET;
    end else begin
      shift_reg <= shift_next;
    end
  end

  // -------------------------------------------------------------
  // apb slave
  // -------------------------------------------------------------
  // zero wait state: ready rises in the first access cycle
  assign apb_write = psel_i & penable_i & pwrite_i & pready_reg;
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ctrl_reg <= `CPAB_CTRL_RESET;
    end else if (apb_write && paddr_i == `CPAB_OFS_CTRL) begin
      ctrl_reg <= {31'h0, pwdata_i[`CPAB_CTRL_TESTER_EN]};
    end
  end
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pready_reg <= 1'b0;
      prdata_reg <= `CPAB_WORD_RESET;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= psel_i & ~penable_i;
      pslverr_reg <= 1'b0;
      prdata_reg <= `CPAB_WORD_RESET;
      if (psel_i && !penable_i) begin
        unique case (paddr_i)
          `CPAB_OFS_CTRL: prdata_reg <= ctrl_reg;
          `CPAB_OFS_WRITE_DATA: prdata_reg <= write_data_reg;
          `CPAB_OFS_SHIFT: prdata_reg <= shift_reg;
          `CPAB_OFS_WORK_ONE: prdata_reg <= work_reg_one;
          `CPAB_OFS_WORK_TWO: prdata_reg <= work_reg_two;
          default: pslverr_reg <= 1'b1;
        endcase
      end
    end
  end
  assign a_mux_data_o = a_mux_reg;
  assign memory_write_data_o = memory_write_buffer_reg[31:0];
  assign tester_data_o = tester_reg;
  assign pready_o = pready_reg;
  assign prdata_o = prdata_reg;
  assign pslverr_o = pslverr_reg;

  // -------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------
  AST_MEM_READ_PATH: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    mem_read_i && load_write_reg_i |=>
      write_data_reg == $past(memory_read_data_i))
    else $error("memory read data not taken by input mux");
  AST_DEFAULT_PATH: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    !mem_read_i && load_rd_two_i |=>
      read_data_reg_two == $past(result_bus_data_i))
    else $error("result bus not default input");
  AST_WRITE_OUT: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    mem_read_i && load_write_reg_i |=>
      ##1 memory_write_data_o == $past(memory_read_data_i, 2))
    else $error("write data late or wrong toward memory");
  AST_SWAP16: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    rotate_func_i == CPAB_ROT_SWAP16 && byte_sel_i == CPAB_BSEL_ALL &&
    !rd_sel_three_i |=>
      a_mux_data_o == ({$past(read_data_reg_two[15:0]),
                        $past(read_data_reg_two[31:16])}
                       | $past(shift_reg)))
    else $error("halfword swap wrong on a mux");
  AST_SINGLE_BYTE: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    byte_sel_i == CPAB_BSEL_SINGLE |->
      (selected_bytes & ~(32'h0000_00ff <<
       {operand_address_reg_one_lo_i[1:0], 3'b000})) == 32'h0000_0000)
    else $error("single byte selection leaked other bytes");
  AST_SHIFT_RIGHT1: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    shift_func_i == CPAB_SHF_RIGHT1 && shift_src_i == CPAB_SRC_WORK_ONE
    |=> shift_reg == ($past(work_reg_one) >> 1))
    else $error("shift right one wrong");
  AST_STORE_CLOCK: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    store_clock_op_i && clock_to_high_i && load_work_two_i |=>
      work_reg_two == {$past(prog_clock_i), 16'h0000})
    else $error("work mux not disabled during clock store");
  AST_PRODUCT: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    mult_ripple_op_i && work_sel_mult_i && !store_clock_op_i &&
    load_work_one_i |=>
      work_reg_one == $past(mult_buf_a_reg[15:0]) *
                      $past(mult_buf_b_reg[15:0]))
    else $error("product wrong in work register");
  AST_MULT_OFF: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    !mult_xlate_op_i && !mult_ripple_op_i && work_sel_mult_i &&
    !store_clock_op_i && load_work_one_i |=> work_reg_one == 32'h0000_0000)
    else $error("multiplier buffers drove while disabled");
  AST_APB_READY: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    psel_i && !penable_i |=> pready_o ##1 !pready_o)
    else $error("apb ready not a single cycle after setup");

endmodule

// ---- testbench/cpab_memctl_model.sv ----
`timescale 1ns/10ps
// ---------------------------------------------------------------
// memory controller stand-in
// ---------------------------------------------------------------
module cpab_memctl_model (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic read_req_i,
  input wire logic pick_three_i,
  input wire logic [31:0] read_word_i,
  output logic mem_read_o,
  output logic rd_sel_three_o,
  output logic [31:0] memory_read_data_o
);
  logic [31:0] last_reg;

  // gating comes from the decoded memory command, not from the datapath
  assign rd_sel_three_o = pick_three_i;
  assign mem_read_o = read_req_i;
  // outside a read the bus shows the inverse of the last word, so a
  // mux that takes memory data at the wrong time cannot match by luck
  assign memory_read_data_o = read_req_i ? read_word_i : ~last_reg;

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      last_reg <= 32'h0000_0000;
    end else if (read_req_i) begin
      last_reg <= read_word_i;
    end
  end
endmodule

// ---- testbench/cp_a_bus_datapath_test.sv ----
`timescale 1ns/10ps
`include "cpab_regs.svh"

`define CPAB_CHECK(got, exp) \
  begin \
    checks++; \
    if ((got) !== (exp)) begin \
      bad_count++; \
      $display("ERROR at %0t: got %h expected %h", $time, got, exp); \
    end \
  end

module cp_a_bus_datapath_test;
  import cpab_pkg::*;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [31:0] result_bus = 32'h0000_0000;
  logic [31:0] read_word = 32'h0000_0000;
  logic read_req = 1'b0;
  logic pick_three = 1'b0;
  logic [3:0] loads = 4'h0; // mult a, write reg, read three, read two
  logic load_mult_b = 1'b0;
  cpab_bsel_t byte_sel = CPAB_BSEL_NONE;
  logic [2:0] adr = 3'h0;
  cpab_rot_t rot_f = CPAB_ROT_PASS;
  cpab_shf_t shf_f = CPAB_SHF_PASS;
  cpab_src_t shf_src = CPAB_SRC_NONE;
  logic [4:0] wctl = 5'h00; // xlate, ripple, product, store clock, high
  logic [15:0] prog = 16'h0000;
  logic ld_one = 1'b0;
  logic ld_two = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] mem_data, a_mux, wr_data, tester, prdata, got;
  logic mem_read, rd_sel_three, pready, pslverr;
  logic [31:0] d2, d3, w, r, ma, mb;
  logic [15:0] p;
  logic [2:0] a;
  int bad_count = 0;
  int checks = 0;
  int cyc = 0;
  int dp_due[$];
  int dp_sel[$];
  logic [31:0] dp_val[$];
  logic [31:0] ap_val[$];
  logic ap_rd[$];
  logic ap_err[$];

  always #50 core_clk = ~core_clk;

  cpab_memctl_model model (.core_clk_i(core_clk), .reset_i(reset),
    .read_req_i(read_req), .pick_three_i(pick_three),
    .read_word_i(read_word), .mem_read_o(mem_read),
    .rd_sel_three_o(rd_sel_three), .memory_read_data_o(mem_data));

  cpab_datapath #(.DATA_W(32)) uut (.core_clk_i(core_clk),
    .reset_i(reset), .result_bus_data_i(result_bus),
    .memory_read_data_i(mem_data), .mem_read_i(mem_read),
    .load_rd_two_i(loads[0]), .load_rd_three_i(loads[1]),
    .load_write_reg_i(loads[2]), .load_mult_a_i(loads[3]),
    .load_mult_b_i(load_mult_b), .rd_sel_three_i(rd_sel_three),
    .byte_sel_i(byte_sel), .operand_address_reg_one_lo_i(adr),
    .rotate_func_i(rot_f), .shift_func_i(shf_f), .shift_src_i(shf_src),
    .work_sel_mult_i(wctl[2]), .store_clock_op_i(wctl[1]),
    .clock_to_high_i(wctl[0]), .prog_clock_i(prog),
    .load_work_one_i(ld_one), .load_work_two_i(ld_two),
    .mult_xlate_op_i(wctl[4]), .mult_ripple_op_i(wctl[3]),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .a_mux_data_o(a_mux),
    .memory_write_data_o(wr_data), .tester_data_o(tester),
    .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr));

  // ---------------------------------------------------------------
  // scoreboard: notes are taken off when their result shows
  // ---------------------------------------------------------------
  always @(negedge core_clk) begin
    cyc = cyc + 1;
    while (dp_due.size() > 0 && dp_due[0] == cyc) begin
      got = dp_sel[0] == 0 ? a_mux : dp_sel[0] == 1 ? wr_data : tester;
      `CPAB_CHECK(got, dp_val[0])
      void'(dp_due.pop_front());
      void'(dp_sel.pop_front());
      void'(dp_val.pop_front());
    end
    if (pready === 1'b1 && ap_rd.size() > 0) begin
      if (ap_rd[0]) `CPAB_CHECK(prdata, ap_val[0])
      `CPAB_CHECK(pslverr, ap_err[0])
      void'(ap_rd.pop_front());
      void'(ap_val.pop_front());
      void'(ap_err.pop_front());
    end
  end

  // ---------------------------------------------------------------
  // tasks and reference functions
  // ---------------------------------------------------------------
  task automatic note(input int sel, input int dly, input logic [31:0] v);
    dp_due.push_back(cyc + dly);
    dp_sel.push_back(sel);
    dp_val.push_back(v);
  endtask

  task automatic settle(input logic [31:0] v);
    repeat (2) @(posedge core_clk);
    note(0, 1, v);
    @(posedge core_clk);
  endtask

  task automatic inmux(input logic mem, input logic [31:0] v,
                       input logic [3:0] tgt);
    read_req <= mem;
    read_word <= v;
    result_bus <= mem ? ~v : v;
    loads <= tgt;
    @(posedge core_clk);
    read_req <= 1'b0;
    loads <= 4'h0;
    @(posedge core_clk);
  endtask

  task automatic apb(input logic wr, input logic [7:0] ad,
                     input logic [31:0] d, input logic [31:0] exp,
                     input logic err);
    ap_rd.push_back(!wr);
    ap_val.push_back(exp);
    ap_err.push_back(err);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // no local limit: the watchdog ends a wait that never gets an answer
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic work_load(input logic two, input logic [4:0] c,
                           input logic [31:0] exp);
    wctl <= c;
    ld_one <= !two;
    ld_two <= two;
    @(posedge core_clk);
    wctl <= 5'h00;
    ld_one <= 1'b0;
    ld_two <= 1'b0;
    @(posedge core_clk);
    apb(0, two ? `CPAB_OFS_WORK_TWO : `CPAB_OFS_WORK_ONE, 0, exp, 0);
  endtask

  function automatic logic [31:0] pick(input logic [31:0] d,
                                       input cpab_bsel_t s,
                                       input logic [2:0] ad);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int k = 0; k < 4; k++) begin
      if (s == CPAB_BSEL_ALL || (s == CPAB_BSEL_SINGLE && k == ad[1:0])
          || (s == CPAB_BSEL_PARTIAL
              && (ad[2] ? k <= ad[1:0] : k >= ad[1:0]))) begin
        m[k*8 +: 8] = 8'hff;
      end
    end
    return d & m;
  endfunction

  function automatic logic [31:0] rot(input logic [31:0] d,
                                      input cpab_rot_t f);
    case (f)
      CPAB_ROT_SWAP16: return {d[15:0], d[31:16]};
      CPAB_ROT_LEFT8: return {d[23:0], d[31:24]};
      CPAB_ROT_RIGHT8: return {d[7:0], d[31:8]};
      default: return d;
    endcase
  endfunction

  task automatic end_test(input string name);
    $display("test %s finished", name);
  endtask

  task automatic complete_run;
    // a note left behind means its result was never looked at
    if (dp_due.size() != 0 || ap_rd.size() != 0) begin
      bad_count++;
      $display("ERROR at %0t: expected results never seen", $time);
    end
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // a hang would otherwise leave the run without a verdict
  initial begin
    #(100 * 4000);
    bad_count++;
    $display("ERROR at %0t: watchdog expired", $time);
    complete_run();
  end

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(27));
    repeat (12) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    apb(0, `CPAB_OFS_CTRL, 0, `CPAB_CTRL_RESET, 0);
    for (int i = 1; i < 5; i++) begin
      apb(0, 8'(4 * i), 0, `CPAB_WORD_RESET, 0);
    end
    apb(1, 8'h14, $urandom, 0, 1);
    apb(0, 8'h14, 0, 0, 1);
    apb(1, `CPAB_OFS_WRITE_DATA, $urandom, 0, 0);
    apb(0, `CPAB_OFS_WRITE_DATA, 0, `CPAB_WORD_RESET, 0);
    end_test("registers");
    r = $urandom;
    note(1, 1, `CPAB_WORD_RESET);
    note(1, 3, r);
    note(2, 3, r);
    inmux(0, r, 4'b0100);
    w = $urandom;
    note(1, 3, w);
    inmux(1, w, 4'b0100);
    apb(0, `CPAB_OFS_WRITE_DATA, 0, w, 0);
    apb(1, `CPAB_OFS_CTRL, 0, 0, 0);
    r = $urandom;
    note(1, 3, r);
    note(2, 3, w);
    inmux(0, r, 4'b0100);
    apb(1, `CPAB_OFS_CTRL, 1, 0, 0);
    end_test("write path");
    d2 = $urandom;
    d3 = $urandom;
    inmux(0, d2, 4'b0001);
    inmux(1, d3, 4'b0010);
    for (int s = 0; s < 2; s++) begin
      for (int b = 0; b < 4; b++) begin
        for (int f = 0; f < 4; f++) begin
          a = 3'($urandom);
          adr <= a;
          pick_three <= s[0];
          byte_sel <= cpab_bsel_t'(b);
          rot_f <= cpab_rot_t'(f);
          settle(rot(pick(s ? d3 : d2, cpab_bsel_t'(b), a),
                     cpab_rot_t'(f)));
        end
      end
    end
    end_test("rotator");
    byte_sel <= CPAB_BSEL_NONE;
    w = $urandom;
    inmux(0, w, 4'b0100);
    shf_src <= CPAB_SRC_WRITE_REG;
    settle(w);
    byte_sel <= CPAB_BSEL_ALL;
    rot_f <= CPAB_ROT_PASS;
    pick_three <= 1'b0;
    settle(d2 | w);
    byte_sel <= CPAB_BSEL_NONE;
    for (int f = 1; f < 4; f++) begin
      shf_src <= CPAB_SRC_WRITE_REG;
      @(posedge core_clk);
      shf_src <= CPAB_SRC_NONE;
      shf_f <= cpab_shf_t'(f);
      @(posedge core_clk);
      shf_f <= CPAB_SHF_PASS;
      settle(f == 1 ? w >> 1 : f == 2 ? w >> 4 : w << 4);
    end
    end_test("shifter");
    ma = $urandom;
    mb = $urandom;
    r = $urandom;
    p = 16'($urandom);
    inmux(0, ma, 4'b1000);
    inmux(0, mb, 4'b0100);
    load_mult_b <= 1'b1;
    @(posedge core_clk);
    load_mult_b <= 1'b0;
    result_bus <= r;
    prog <= p;
    @(posedge core_clk);
    work_load(0, 5'b10100, ma[15:0] * mb[15:0]);
    work_load(1, 5'b01100, ma[15:0] * mb[15:0]);
    work_load(0, 5'b00100, 32'h0000_0000);
    work_load(1, 5'b00000, r);
    work_load(0, 5'b00011, {p, 16'h0000});
    work_load(1, 5'b00010, {16'h0000, p});
    shf_src <= CPAB_SRC_WORK_ONE;
    settle({p, 16'h0000});
    shf_src <= CPAB_SRC_WORK_TWO;
    settle({16'h0000, p});
    end_test("work and multiplier");
    complete_run();
  end
endmodule
